// File: core/dma_chain_ctrl.sv
// Single DMA channel with buffer chaining, replay, contiguous addressing
//
// Operation
// - Contiguous side continues after previous buffer end
// - Buffer interrupt only when its mask set
// - Buffer interrupt after last destination write
// - Chain interrupt only when its mask set
// - Single-buffer state after buffer ends transfer
// - Zero pointer plus replay keeps starting buffers
// - Three registers select single or multi-buffer
// - Reading interrupt status clears pending flags
// - Handshake select picks hardware or software requests
// - Peripheral number binds the handshake lines
// - Window mode uses that side's window register
// - Start needs start write and global switch
// - Acknowledge each transaction until buffer moved
// - Final buffer sets flags, clears channel on
// - Control words give flow, widths, layers, steps
// - Descriptor fetch overwrites channel registers
// - Updated control A written back after each buffer fetched from a descriptor
`timescale 1ns/10ps
module dma_chain_ctrl
  import dma_chain_pkg::*;
#(
  parameter int NUM_PER = 16
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // System memory master
  output logic                    mem_req,
  output logic                    mem_we,
  output logic      [31:0]        mem_addr,
  output logic      [31:0]        mem_wdata,
  output logic                    mem_layer,
  input  wire logic               mem_ready,
  input  wire logic [31:0]        mem_rdata,
  // Peripheral handshake
  input  wire logic [NUM_PER-1:0] src_hw_req,
  input  wire logic [NUM_PER-1:0] dst_hw_req,
  output logic      [NUM_PER-1:0] src_hw_ack,
  output logic      [NUM_PER-1:0] dst_hw_ack,
  // Completion events
  output logic                    buffer_done_irq,
  output logic                    chain_done_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    chan_state_type       st;
    logic                 glob_en;
    logic                 ch_on;
    logic [1:0]           mask;
    logic [1:0]           irq_st;
    logic [31:0]          saddr;
    logic [31:0]          daddr;
    logic [31:0]          dscr;
    logic [31:0]          ctrla;
    logic [31:0]          ctrlb;
    logic [31:0]          cfg;
    logic [31:0]          swin;
    logic [31:0]          dwin;
    logic [1:0]           swreq;
    logic [31:0]          init_saddr;
    logic [31:0]          init_daddr;
    logic [31:0]          init_ctrla;
    logic [CA_LEN_W-1:0]  remain;
    logic [2:0]           fidx;
    logic [31:0]          fetch_base;
    logic                 fetch_layer;
    logic                 linked;
    logic [31:0]          data;
    logic [15:0]          spip_cnt;
    logic [15:0]          dpip_cnt;
    logic [31:0]          rdata;
  } chan_type;

  chan_type s_reg;
  chan_type s_next;

  logic src_go;
  logic dst_go;
  logic word_done;

  // ----------------------------------------------------------------
  // Address stepping
  // ----------------------------------------------------------------
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] step,
                                            input logic [1:0] size, input logic pip,
                                            input logic [15:0] cnt, input logic [31:0] win);
    logic [31:0] bytes;
    logic [31:0] r;
    bytes = 32'h1 << size;
    if (step == STEP_INC) begin
      r = a + bytes;
    end else if (step == STEP_DEC) begin
      r = a - bytes;
    end else begin
      r = a;
    end
    // Jump the window hole at each boundary
    if (pip && (cnt + 16'h1) == win[WIN_BOUND_LSB +: 16]) begin
      r = r + {16'h0, win[WIN_HOLE_LSB +: 16]};
    end
    return r;
  endfunction

  function automatic logic [15:0] step_cnt(input logic pip, input logic [15:0] cnt,
                                           input logic [31:0] win);
    if (!pip || (cnt + 16'h1) == win[WIN_BOUND_LSB +: 16]) begin
      return 16'h0;
    end
    return cnt + 16'h1;
  endfunction

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  assign word_done = s_reg.glob_en && (s_reg.st == ST_WRITE) && dst_go && mem_ready;

  dma_req_select #(.NUM_PER(NUM_PER)) u_src_sel (
    .hw_req      (src_hw_req),
    .hw_ack      (src_hw_ack),
    .periph_num  (s_reg.cfg[CF_SPER_LSB +: CF_PER_W]),
    .hw_select   (s_reg.cfg[CF_SHW]),
    .periph_side (s_reg.ctrlb[CB_FC_SOURCE_PERIPHERAL_NUMBER]),
    .sw_req      (s_reg.swreq[REQ_SRC]),
    .done        (word_done),
    .go          (src_go)
  );

  dma_req_select #(.NUM_PER(NUM_PER)) u_dst_sel (
    .hw_req      (dst_hw_req),
    .hw_ack      (dst_hw_ack),
    .periph_num  (s_reg.cfg[CF_DPER_LSB +: CF_PER_W]),
    .hw_select   (s_reg.cfg[CF_DHW]),
    .periph_side (s_reg.ctrlb[CB_FC_DEST_PERIPHERAL_NUMBER]),
    .sw_req      (s_reg.swreq[REQ_DST]),
    .done        (word_done),
    .go          (dst_go)
  );

  // ----------------------------------------------------------------
  // Memory master
  // ----------------------------------------------------------------
  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = s_reg.fetch_base + {27'h0, s_reg.fidx, 2'b00};
    mem_layer = s_reg.fetch_layer;
    mem_wdata = s_reg.data;
    if (s_reg.glob_en) begin
      case (s_reg.st)
        ST_FETCH: begin
          mem_req = 1'b1;
        end
        ST_READ: begin
          mem_req   = (s_reg.remain != '0) && src_go;
          mem_addr  = s_reg.saddr;
          mem_layer = s_reg.ctrlb[CB_SLAYER];
        end
        ST_WRITE: begin
          mem_req   = dst_go;
          mem_we    = 1'b1;
          mem_addr  = s_reg.daddr;
          mem_layer = s_reg.ctrlb[CB_DLAYER];
        end
        ST_WBACK: begin
          mem_req   = 1'b1;
          mem_we    = 1'b1;
          mem_addr  = s_reg.fetch_base + CTRLA_OFS;
          mem_wdata = s_reg.ctrla;
        end
        default: begin
          mem_req = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register port and channel sequencing
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (reg_rd) begin
      case (reg_addr)
        OFS_GLOBAL_SWITCH: s_next.rdata = {31'h0, s_reg.glob_en};
        OFS_CHANNEL_STAT:  s_next.rdata = {31'h0, s_reg.ch_on};
        OFS_IRQ_MASK:      s_next.rdata = {30'h0, s_reg.mask};
        OFS_IRQ_STATUS:    s_next.rdata = {30'h0, s_reg.irq_st};
        OFS_SOURCE_ADDR:   s_next.rdata = s_reg.saddr;
        OFS_DEST_ADDR:     s_next.rdata = s_reg.daddr;
        OFS_NEXT_DESC:     s_next.rdata = s_reg.dscr;
        OFS_CONTROL_A:     s_next.rdata = s_reg.ctrla;
        OFS_CONTROL_B:     s_next.rdata = s_reg.ctrlb;
        OFS_CHANNEL_CFG:   s_next.rdata = s_reg.cfg;
        OFS_SOURCE_WIN:    s_next.rdata = s_reg.swin;
        OFS_DEST_WIN:      s_next.rdata = s_reg.dwin;
        OFS_SW_REQUEST:    s_next.rdata = {30'h0, s_reg.swreq};
        default:           s_next.rdata = WORD_RESET;
      endcase
      if (reg_addr == OFS_IRQ_STATUS) begin
        s_next.irq_st = 2'h0;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        OFS_GLOBAL_SWITCH: s_next.glob_en = reg_wdata[0];
        OFS_IRQ_MASK:      s_next.mask    = reg_wdata[1:0];
        OFS_SOURCE_ADDR:   s_next.saddr   = reg_wdata;
        OFS_DEST_ADDR:     s_next.daddr   = reg_wdata;
        OFS_NEXT_DESC:     s_next.dscr    = reg_wdata;
        OFS_CONTROL_A:     s_next.ctrla   = reg_wdata;
        OFS_CONTROL_B:     s_next.ctrlb   = reg_wdata;
        OFS_CHANNEL_CFG:   s_next.cfg     = reg_wdata;
        OFS_SOURCE_WIN:    s_next.swin    = reg_wdata;
        OFS_DEST_WIN:      s_next.dwin    = reg_wdata;
        OFS_SW_REQUEST:    s_next.swreq   = s_reg.swreq | reg_wdata[1:0];
        default:           s_next.mask    = s_next.mask;
      endcase
      // Replay values are captured here so later writes cannot disturb them
      if (reg_addr == OFS_CHANNEL_START && reg_wdata[0] && s_reg.glob_en &&
          !s_reg.ch_on) begin
        s_next.ch_on      = 1'b1;
        s_next.init_saddr = s_reg.saddr;
        s_next.init_daddr = s_reg.daddr;
        s_next.init_ctrla = s_reg.ctrla;
        s_next.remain     = s_reg.ctrla[CA_LEN_LSB +: CA_LEN_W];
        s_next.linked     = 1'b0;
        s_next.spip_cnt   = 16'h0;
        s_next.dpip_cnt   = 16'h0;
        s_next.fidx       = DESC_LAST;
        s_next.fetch_base = {s_reg.dscr[31:2], 2'b00};
        s_next.fetch_layer = s_reg.dscr[0];
        s_next.st         = (s_reg.dscr != '0) ? ST_FETCH : ST_READ;
      end
    end

    // Clearing the global switch suspends the channel in place
    if (s_reg.glob_en) begin
      case (s_reg.st)
        ST_FETCH: begin
          if (mem_ready) begin
            case (s_reg.fidx)
              DESC_LAST:  s_next.ctrlb = mem_rdata;
              DESC_CTRLA: s_next.ctrla = mem_rdata;
              3'h2: s_next.dscr  = mem_rdata;
              3'h1: begin
                if (!s_reg.ctrlb[CB_DSKIP]) begin
                  s_next.daddr = mem_rdata;
                end else if (s_reg.cfg[CF_DREL]) begin
                  s_next.daddr = s_reg.init_daddr;
                end
              end
              default: begin
                if (!s_reg.ctrlb[CB_SSKIP]) begin
                  s_next.saddr = mem_rdata;
                end else if (s_reg.cfg[CF_SREL]) begin
                  s_next.saddr = s_reg.init_saddr;
                end
              end
            endcase
            if (s_reg.fidx == '0) begin
              s_next.remain   = s_reg.ctrla[CA_LEN_LSB +: CA_LEN_W];
              s_next.linked   = 1'b1;
              s_next.spip_cnt = 16'h0;
              s_next.dpip_cnt = 16'h0;
              s_next.st       = ST_READ;
            end else begin
              s_next.fidx = s_reg.fidx - 3'h1;
            end
          end
        end
        ST_READ: begin
          if (s_reg.remain == '0) begin
            s_next.ctrla[CA_DONE] = 1'b1;
            s_next.st = s_reg.linked ? ST_WBACK : ST_DECIDE;
          end else if (src_go && mem_ready) begin
            s_next.data = mem_rdata;
            s_next.st   = ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (word_done) begin
            s_next.saddr    = step_addr(s_reg.saddr, s_reg.ctrlb[CB_SSTEP_LSB +: 2],
                                        s_reg.ctrla[CA_SSIZE_LSB +: 2], s_reg.ctrlb[CB_SPIP],
                                        s_reg.spip_cnt, s_reg.swin);
            s_next.daddr    = step_addr(s_reg.daddr, s_reg.ctrlb[CB_DSTEP_LSB +: 2],
                                        s_reg.ctrla[CA_DSIZE_LSB +: 2], s_reg.ctrlb[CB_DPIP],
                                        s_reg.dpip_cnt, s_reg.dwin);
            s_next.spip_cnt = step_cnt(s_reg.ctrlb[CB_SPIP], s_reg.spip_cnt, s_reg.swin);
            s_next.dpip_cnt = step_cnt(s_reg.ctrlb[CB_DPIP], s_reg.dpip_cnt, s_reg.dwin);
            s_next.remain   = s_reg.remain - 16'h1;
            s_next.swreq    = 2'h0;
            s_next.st       = ST_READ;
          end
        end
        ST_WBACK: begin
          if (mem_ready) begin
            s_next.st = ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          s_next.irq_st[IRQ_BUF] = 1'b1;
          if (!s_reg.ctrlb[CB_AUTO] && s_reg.dscr == '0) begin
            s_next.irq_st[IRQ_CHAIN] = 1'b1;
            s_next.ch_on = 1'b0;
            s_next.st    = ST_IDLE;
          end else if (s_reg.dscr != '0) begin
            s_next.fidx        = DESC_LAST;
            s_next.fetch_base  = {s_reg.dscr[31:2], 2'b00};
            s_next.fetch_layer = s_reg.dscr[0];
            s_next.st          = ST_FETCH;
          end else begin
            // Control B is not replayed so software can still drop replay
            if (s_reg.cfg[CF_SREL]) begin
              s_next.saddr = s_reg.init_saddr;
            end
            if (s_reg.cfg[CF_DREL]) begin
              s_next.daddr = s_reg.init_daddr;
            end
            s_next.ctrla    = s_reg.init_ctrla;
            s_next.remain   = s_reg.init_ctrla[CA_LEN_LSB +: CA_LEN_W];
            s_next.spip_cnt = 16'h0;
            s_next.dpip_cnt = 16'h0;
            s_next.st       = ST_READ;
          end
        end
        default: begin
          s_next.st = s_next.st;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg    <= '0;
      s_reg.st <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata       = s_reg.rdata;
  assign buffer_done_irq = s_reg.irq_st[IRQ_BUF] && s_reg.mask[IRQ_BUF];
  assign chain_done_irq  = s_reg.irq_st[IRQ_CHAIN] && s_reg.mask[IRQ_CHAIN];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_word_inc;
    word_done && s_reg.ctrlb[CB_SSTEP_LSB +: 2] == STEP_INC && !s_reg.ctrlb[CB_SPIP];
  endsequence
  sequence s_last_word;
    s_reg.st == ST_READ && s_reg.remain == '0 && s_reg.glob_en && !s_reg.linked;
  endsequence

  a_buf_irq_mask: assert property (buffer_done_irq |-> s_reg.mask[IRQ_BUF])
    else $error("buffer interrupt while masked");
  a_chain_irq_mask: assert property (chain_done_irq |-> s_reg.mask[IRQ_CHAIN])
    else $error("chain interrupt while masked");
  a_buf_irq_raise: assert property ((s_reg.st == ST_DECIDE && s_reg.glob_en) ##1
    s_reg.mask[IRQ_BUF] |-> buffer_done_irq)
    else $error("buffer interrupt missing at buffer end");
  a_chain_irq_raise: assert property ((s_reg.st == ST_DECIDE && s_reg.glob_en &&
    !s_reg.ctrlb[CB_AUTO] && s_reg.dscr == '0) ##1 s_reg.mask[IRQ_CHAIN] |-> chain_done_irq)
    else $error("chain interrupt missing at chain end");
  a_buf_after_write: assert property ($rose(s_reg.irq_st[IRQ_BUF]) |->
    $past(s_reg.st) == ST_DECIDE)
    else $error("buffer flag set outside buffer end");
  a_end_single: assert property (s_last_word ##1 (!s_reg.ctrlb[CB_AUTO] &&
    s_reg.dscr == '0 && s_reg.glob_en) |=> !s_reg.ch_on && s_reg.irq_st[IRQ_CHAIN])
    else $error("single buffer did not end transfer");
  a_replay_cont: assert property (s_reg.st == ST_DECIDE && s_reg.glob_en &&
    s_reg.ctrlb[CB_AUTO] && s_reg.dscr == '0 |=> s_reg.st == ST_READ && s_reg.ch_on)
    else $error("replay did not start new buffer");
  a_status_clear: assert property (reg_rd && reg_addr == OFS_IRQ_STATUS &&
    s_reg.st != ST_DECIDE |=> s_reg.irq_st == 2'h0)
    else $error("status read did not clear flags");
  a_start_gate: assert property ($rose(s_reg.ch_on) |->
    $past(reg_wr) && $past(reg_addr) == OFS_CHANNEL_START && $past(s_reg.glob_en))
    else $error("channel started without start and switch");
  a_contig_step: assert property (s_word_inc |=>
    s_reg.saddr == $past(s_reg.saddr) + (32'h1 << $past(s_reg.ctrla[CA_SSIZE_LSB +: 2])))
    else $error("source address not contiguous");
  a_fetch_load: assert property (s_reg.st == ST_FETCH && s_reg.fidx == '0 && mem_ready &&
    s_reg.glob_en |=> s_reg.st == ST_READ && s_reg.remain == s_reg.ctrla[CA_LEN_W-1:0])
    else $error("descriptor length not loaded");
  a_wback_addr: assert property (s_reg.st == ST_WBACK && s_reg.glob_en |->
    mem_req && mem_we && mem_addr == s_reg.fetch_base + CTRLA_OFS &&
    mem_wdata[CA_DONE])
    else $error("write back to wrong place");
  a_end_off: assert property (s_reg.ch_on ##1 !s_reg.ch_on |->
    s_reg.irq_st[IRQ_CHAIN] && s_reg.irq_st[IRQ_BUF] && s_reg.st == ST_IDLE)
    else $error("channel stopped without flags");

endmodule // dma_chain_ctrl

// File: core/dma_chain_pkg.sv
// Shared constants, register offsets and field layout of the channel controller
package dma_chain_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GLOBAL_SWITCH = 8'h00;
  localparam logic [7:0] OFS_CHANNEL_START = 8'h04;
  localparam logic [7:0] OFS_CHANNEL_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h10;
  localparam logic [7:0] OFS_SOURCE_ADDR   = 8'h14;
  localparam logic [7:0] OFS_DEST_ADDR     = 8'h18;
  localparam logic [7:0] OFS_NEXT_DESC     = 8'h1c;
  localparam logic [7:0] OFS_CONTROL_A     = 8'h20;
  localparam logic [7:0] OFS_CONTROL_B     = 8'h24;
  localparam logic [7:0] OFS_CHANNEL_CFG   = 8'h28;
  localparam logic [7:0] OFS_SOURCE_WIN    = 8'h2c;
  localparam logic [7:0] OFS_DEST_WIN      = 8'h30;
  localparam logic [7:0] OFS_SW_REQUEST    = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_LEN_LSB    = 0;
  localparam int CA_LEN_W      = 16;
  localparam int CA_SSIZE_LSB  = 16;
  localparam int CA_DSIZE_LSB  = 18;
  localparam int CA_DONE       = 31;
  localparam int CB_SLAYER     = 0;
  localparam int CB_DLAYER     = 1;
  localparam int CB_FC_SOURCE_PERIPHERAL_NUMBER = 3;
  localparam int CB_FC_DEST_PERIPHERAL_NUMBER = 2;
  localparam int CB_SSTEP_LSB  = 4;
  localparam int CB_DSTEP_LSB  = 6;
  localparam int CB_SSKIP      = 8;
  localparam int CB_DSKIP      = 9;
  localparam int CB_SPIP       = 10;
  localparam int CB_DPIP       = 11;
  localparam int CB_AUTO       = 12;
  localparam int CF_SPER_LSB   = 0;
  localparam int CF_DPER_LSB   = 4;
  localparam int CF_PER_W      = 4;
  localparam int CF_SHW        = 8;
  localparam int CF_DHW        = 9;
  localparam int CF_SREL       = 10;
  localparam int CF_DREL       = 11;
  localparam int WIN_HOLE_LSB  = 0;
  localparam int WIN_BOUND_LSB = 16;
  localparam int IRQ_BUF       = 0;
  localparam int IRQ_CHAIN     = 1;
  localparam int REQ_SRC       = 0;
  localparam int REQ_DST       = 1;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  STEP_INC   = 2'h0;
  localparam logic [1:0]  STEP_DEC   = 2'h1;
  localparam logic [2:0]  DESC_LAST  = 3'h4;
  localparam logic [2:0]  DESC_CTRLA = 3'h3;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRLA_OFS  = 32'h0000_000c;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_FETCH  = 6'h02,
    ST_READ   = 6'h04,
    ST_WRITE  = 6'h08,
    ST_WBACK  = 6'h10,
    ST_DECIDE = 6'h20
  } chan_state_type;

endpackage

// File: core/dma_req_select.sv
// Request selection and acknowledge routing for one side of the channel
`timescale 1ns/10ps
module dma_req_select
  import dma_chain_pkg::*;
#(
  parameter int NUM_PER = 16
) (
  // Peripheral handshake lines
  input  wire logic [NUM_PER-1:0]  hw_req,
  output logic      [NUM_PER-1:0]  hw_ack,
  // Channel setup
  input  wire logic [CF_PER_W-1:0] periph_num,
  input  wire logic                hw_select,
  input  wire logic                periph_side,
  input  wire logic                sw_req,
  // Transfer engine
  input  wire logic                done,
  output logic                     go
);

  // Memory side always ready; peripherals use the chosen handshake
  assign go = !periph_side || (hw_select ? hw_req[periph_num] : sw_req);

  // Ack only the bound line, and only under hardware handshaking
  assign hw_ack = (done && periph_side && hw_select) ?
                  (NUM_PER'(1) << periph_num) : '0;

endmodule // dma_req_select

// File: tb/dma_chain_ctrl_test.sv
// Self-checking bench for the chained DMA channel
`timescale 1ns/10ps
module dma_chain_ctrl_test;
  import dma_chain_pkg::*;
  logic        clk, sys_rst, reg_wr, reg_rd, slow, mem_req, mem_we, mem_layer, mem_ready;
  logic        buffer_done_irq, chain_done_irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [15:0] src_hw_req, dst_hw_req, src_hw_ack, dst_hw_ack;
  int          n_errors, num_checks, i;

  dma_chain_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_layer(mem_layer), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .src_hw_req(src_hw_req), .dst_hw_req(dst_hw_req), .src_hw_ack(src_hw_ack),
    .dst_hw_ack(dst_hw_ack), .buffer_done_irq(buffer_done_irq),
    .chain_done_irq(chain_done_irq));
  dma_mem_model mem_m (.clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .slow(slow));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Register port and checking tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic give_up(input string nm);
    chk(nm, 1, 0);
    conclude();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
    if (nm != "") chk(nm, e, rd);
  endtask
  task automatic mchk(input logic [31:0] d, input logic [31:0] s);
    chk("dst_word", 32'h5a00_0000 + (s >> 2), mem_m.mem[d[9:2]]);
  endtask
  task automatic setup(input logic [31:0] s, dd, p, b, c);
    rchk("", OFS_IRQ_STATUS, 0);
    wr(OFS_SOURCE_ADDR, s);
    wr(OFS_DEST_ADDR, dd);
    wr(OFS_NEXT_DESC, p);
    wr(OFS_CONTROL_A, 32'h000a_0002);
    wr(OFS_CONTROL_B, b);
    wr(OFS_CHANNEL_CFG, c);
    wr(OFS_CHANNEL_START, 32'h0000_0001);
  endtask
  // Bounded poll; a hang ends the run
  task automatic wait_off();
    for (i = 0; i < 300; i++) begin
      rchk("", OFS_CHANNEL_STAT, 0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 300) begin
      chk("chan_on", 0, 1);
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, slow, reg_addr, reg_wdata, src_hw_req, dst_hw_req} = '0;
    n_errors = 0;
    num_checks = 0;
    for (i = 0; i < 256; i++) mem_m.mem[i] = 32'h5a00_0000 + i;
    // Two descriptors: first points on, last ends with both skips set
    mem_m.mem[8'h40] = 32'h40;
    mem_m.mem[8'h41] = 32'h180;
    mem_m.mem[8'h42] = 32'h120;
    mem_m.mem[8'h43] = 32'h000a_0002;
    mem_m.mem[8'h44] = 32'h0;
    mem_m.mem[8'h48] = 32'h50;
    mem_m.mem[8'h49] = 32'h0;
    mem_m.mem[8'h4a] = 32'h0;
    mem_m.mem[8'h4b] = 32'h000a_0002;
    mem_m.mem[8'h4c] = 32'h300;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rchk("chan_reset", OFS_CHANNEL_STAT, 0);
    rchk("unmapped", 8'hfc, 0);
    wr(OFS_IRQ_MASK, 32'h3);
    setup(32'h40, 32'hc0, 0, 0, 0);
    rchk("start_off", OFS_CHANNEL_STAT, 0);
    wr(OFS_GLOBAL_SWITCH, 32'h1);
    wr(OFS_CHANNEL_START, 32'h1);
    wait_off();
    mchk(32'hc0, 32'h40);
    mchk(32'hc4, 32'h44);
    chk("irq_outs", 3, {30'h0, chain_done_irq, buffer_done_irq});
    rchk("irq_stat", OFS_IRQ_STATUS, 3);
    rchk("irq_clear", OFS_IRQ_STATUS, 0);
    chk("irq_low", 0, {30'h0, chain_done_irq, buffer_done_irq});
    $display("single buffer test done");
    slow <= 1'b1;
    wr(OFS_IRQ_MASK, 32'h1);
    setup(0, 0, 32'h100, 0, 0);
    wait_off();
    mchk(32'h180, 32'h40);
    mchk(32'h184, 32'h44);
    mchk(32'h188, 32'h48);
    mchk(32'h18c, 32'h4c);
    chk("done_bit0", 1, {31'h0, mem_m.mem[8'h43][31]});
    chk("done_bit1", 1, {31'h0, mem_m.mem[8'h4b][31]});
    chk("masked_irq", 1, {30'h0, chain_done_irq, buffer_done_irq});
    $display("linked list test done");
    slow <= 1'b0;
    wr(OFS_IRQ_MASK, 32'h3);
    setup(32'h40, 32'h1c0, 0, 32'h1300, 32'hc00);
    for (i = 0; i < 300 && buffer_done_irq !== 1'b1; i++) @(posedge clk);
    if (i == 300) give_up("buf_irq_wait");
    rchk("replay_on", OFS_CHANNEL_STAT, 1);
    wr(OFS_CONTROL_B, 0);
    wait_off();
    mchk(32'h1c4, 32'h44);
    rchk("replay_end", OFS_IRQ_STATUS, 3);
    $display("replay test done");
    setup(32'h40, 32'h1e0, 0, 32'he, 32'h353);
    repeat (10) @(posedge clk);
    rchk("no_request", OFS_CHANNEL_STAT, 1);
    src_hw_req <= 16'h0008;
    dst_hw_req <= 16'h0020;
    for (i = 0; i < 300 && src_hw_ack === 16'h0; i++) @(posedge clk) #1;
    if (i == 300) give_up("ack_wait");
    chk("ack_line", 32'h8, {16'h0, src_hw_ack});
    chk("dst_ack", 32'h20, {16'h0, dst_hw_ack});
    chk("dst_layer", 1, {31'h0, mem_layer});
    wait_off();
    src_hw_req <= 16'h0;
    dst_hw_req <= 16'h0;
    mchk(32'h1e4, 32'h44);
    $display("handshake test done");
    setup(32'h40, 32'h1f0, 0, 32'h4, 0);
    repeat (2) begin
      repeat (6) @(posedge clk);
      rchk("sw_pending", OFS_CHANNEL_STAT, 1);
      wr(OFS_SW_REQUEST, 32'h2);
    end
    wait_off();
    mchk(32'h1f4, 32'h44);
    $display("software request test done");
    conclude();
  end
endmodule // dma_chain_ctrl_test

// File: tb/dma_mem_model.sv
// Behavioural system memory answering the channel's bus master
`timescale 1ns/10ps
module dma_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Bus from the channel
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ready,
  output logic      [31:0] mem_rdata,
  // Answer speed
  input  wire logic        slow
);
  logic [31:0] mem [256];
  logic [1:0]  wait_reg;
  // Slow mode adds two wait cycles to every access
  assign mem_ready = mem_req && (!slow || wait_reg == 2'h2);
  // Inverted outside ready, so stale data never passes for good data
  assign mem_rdata = mem_ready ? mem[mem_addr[9:2]] : ~mem[mem_addr[9:2]];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= (mem_req && !mem_ready) ? wait_reg + 2'h1 : 2'h0;
      if (mem_ready && mem_we) begin
        mem[mem_addr[9:2]] <= mem_wdata;
      end
    end
  end
endmodule // dma_mem_model
